// ==== logic/atp_pkg.sv ====
// Shared constants and types for the dual-channel TDM transcoder port.
package atp_pkg;
	localparam int NCH = 2;
	localparam int CH_X = 0;
	localparam int CH_Y = 1;

	// System clock and the idle-exit settling time.
	localparam int CLK_HZ = 20_000_000;
	localparam int WAKE_TIME_MS = 800;
	localparam int WAKE_CYCLES_DEF = WAKE_TIME_MS * (CLK_HZ / 1000);
	localparam int WAKE_W = 24;

	// Cycles after reset release at which the algorithm straps are judged.
	localparam logic [2:0] STRAP_CAPT_CYC = 3'h6;

	// APB byte addresses.
	localparam logic [7:0] REG_X_CTRL = 8'h00;
	localparam logic [7:0] REG_X_ITR = 8'h04;
	localparam logic [7:0] REG_X_OTR = 8'h08;
	localparam logic [7:0] REG_Y_CTRL = 8'h10;
	localparam logic [7:0] REG_Y_ITR = 8'h14;
	localparam logic [7:0] REG_Y_OTR = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h20;

	// Hardware-mode pin roles on the address pins.
	localparam int ADDR_DIR_X = 0;
	localparam int ADDR_ALG_A = 1;
	localparam int ADDR_LAW_X = 2;
	localparam int ADDR_DIR_Y = 3;
	localparam int ADDR_ALG_B = 4;
	localparam int ADDR_LAW_Y = 5;

	// Algorithm select codes {as2, as1, as0}.
	localparam logic [2:0] AS_32K = 3'h0;
	localparam logic [2:0] AS_24K = 3'h7;
	localparam logic [2:0] AS_16K = 3'h5;

	localparam logic [5:0] HW_SLOT = 6'h00;
	localparam logic [8:0] POS_MAX = 9'h1FF;
	localparam logic [1:0] FS_SAT = 2'h3;
	localparam logic [1:0] FS_WIDE = 2'h2;
	localparam logic [1:0] ADPCM_MSB = 2'h3;
	localparam logic [2:0] PCM_MSB = 3'h7;
	localparam logic [3:0] NIB_ZERO = 4'h0;

	typedef enum logic [1:0] {ALG_32K, ALG_24K, ALG_16K} atp_alg_t;
	typedef enum logic [1:0] {CH_RUN, CH_IDLE, CH_WAKE} atp_ch_st_t;

	// Control register, MSB first.
	typedef struct packed {
		logic as0;
		logic as1;
		logic idle;
		logic alrst;
		logic byp;
		logic law;
		logic as2;
		logic dir;
	} atp_ctrl_t;

	typedef struct packed {
		atp_ctrl_t ctrl;
		logic [5:0] islot;
		logic [5:0] oslot;
	} atp_cfg_t;

	typedef struct packed {
		logic [NCH-1:0] clk;
		logic [NCH-1:0] fs;
		logic [NCH-1:0] din;
		logic strap;
		logic [5:0] addr;
		logic ser_in;
		logic port_sel;
	} atp_pins_t;

	typedef struct packed {
		logic run_y;
		logic run_x;
		atp_alg_t alg_y;
		atp_alg_t alg_x;
		logic low_power;
		logic hw_mode;
	} atp_status_t;

	typedef struct packed {
		atp_ch_st_t st;
		logic [WAKE_W-1:0] wake;
		atp_cfg_t cfg;
		atp_alg_t alg;
		logic [8:0] pos;
		logic [1:0] fs_cnt;
		logic armed;
		logic run;
		logic drive;
		logic so;
		logic oe;
		logic pad;
		logic [7:0] word;
		logic [7:0] shift;
		logic [7:0] res;
	} atp_chan_t;
endpackage : atp_pkg

// ==== logic/atp_tdm_port.sv ====
// Dual-channel TDM serial port with strap-selected hardware mode and APB control.
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module atp_tdm_port import atp_pkg::*; #(
	parameter int unsigned WAKE_CYCLES = WAKE_CYCLES_DEF
) (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_host_mode_strap,
	input wire logic [5:0] i_addr_pin,
	input wire logic i_serial_in_pin,
	input wire logic i_port_select_pin,
	input wire logic i_chan_x_bit_clock,
	input wire logic i_chan_y_bit_clock,
	input wire logic i_chan_x_frame_sync,
	input wire logic i_chan_y_frame_sync,
	input wire logic i_chan_x_serial_in,
	input wire logic i_chan_y_serial_in,
	output logic o_chan_x_serial_out,
	output logic o_chan_x_serial_out_oe,
	output logic o_chan_y_serial_out,
	output logic o_chan_y_serial_out_oe,
	output logic o_low_power
);

	function automatic atp_alg_t alg_dec(input atp_ctrl_t c);
		logic [2:0] as;
		as = {c.as2, c.as1, c.as0};
		if (as == AS_24K)
			return ALG_24K;
		else if (as == AS_16K)
			return ALG_16K;
		return ALG_32K;
	endfunction : alg_dec

	// Four-bit slots index by pos/4, eight-bit slots by pos/8.
	function automatic logic slot_hit(input logic [8:0] pos, input logic [5:0] slot, input logic nib);
		if (nib)
			return pos[8:2] == {1'b0, slot};
		return pos[8:3] == slot;
	endfunction : slot_hit

	function automatic logic out_bit(input atp_chan_t c);
		logic [1:0] b;
		b = c.pos[1:0];
		if (!c.cfg.ctrl.dir)
			return c.word[PCM_MSB - c.pos[2:0]];
		case (c.alg)
			ALG_24K: return (b == ADPCM_MSB) ? c.pad : c.word[ADPCM_MSB - b];
			ALG_16K: return b[1] ? 1'b0 : c.word[ADPCM_MSB - b];
			default: return c.word[ADPCM_MSB - b];
		endcase
	endfunction : out_bit

	atp_pins_t pins_raw;
	atp_pins_t s1_q;
	atp_pins_t s2_q;
	atp_pins_t s3_q;
	atp_pins_t pf_q;
	atp_pins_t pf_d;
	logic [NCH-1:0] clkp_q;
	logic [NCH-1:0] rise;
	logic [NCH-1:0] fall;
	logic hw_mode;
	logic upd;
	logic [2:0] rel_cnt_q;
	logic [2:0] rel_cnt_d;
	logic a_low_q;
	logic a_low_d;
	atp_alg_t hw_alg;
	atp_ctrl_t reg_ctrl_q [NCH];
	atp_ctrl_t reg_ctrl_d [NCH];
	logic [5:0] reg_itr_q [NCH];
	logic [5:0] reg_itr_d [NCH];
	logic [5:0] reg_otr_q [NCH];
	logic [5:0] reg_otr_d [NCH];
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic apb_hit;
	atp_status_t status;
	atp_cfg_t live_cfg [NCH];
	atp_chan_t ch_q [NCH];
	atp_chan_t ch_d [NCH];

	// Every outside pin goes through three flops; a level is taken once stages two and three agree.
	always_comb
	begin
		pins_raw.clk = {i_chan_y_bit_clock, i_chan_x_bit_clock};
		pins_raw.fs = {i_chan_y_frame_sync, i_chan_x_frame_sync};
		pins_raw.din = {i_chan_y_serial_in, i_chan_x_serial_in};
		pins_raw.strap = i_host_mode_strap;
		pins_raw.addr = i_addr_pin;
		pins_raw.ser_in = i_serial_in_pin;
		pins_raw.port_sel = i_port_select_pin;
		pf_d = atp_pins_t'((s2_q & s3_q) | (pf_q & (s2_q ^ s3_q)));
		rise = pf_q.clk & ~clkp_q;
		fall = ~pf_q.clk & clkp_q;
	end

	assign hw_mode = !pf_q.strap;
	assign upd = i_psel && i_pwrite && !hw_mode;

	// The 24k choice is a low level seen just after reset followed by a later high.
	always_comb
	begin
		rel_cnt_d = rel_cnt_q;
		a_low_d = a_low_q;
		if (rel_cnt_q != STRAP_CAPT_CYC)
			rel_cnt_d = rel_cnt_q + 3'h1;
		if (rel_cnt_q == STRAP_CAPT_CYC - 3'h1)
			a_low_d = !(pf_q.addr[ADDR_ALG_A] || pf_q.addr[ADDR_ALG_B]);
		if (!(pf_q.addr[ADDR_ALG_A] && pf_q.addr[ADDR_ALG_B]))
			hw_alg = ALG_32K;
		else
			hw_alg = a_low_q ? ALG_24K : ALG_16K;
	end

	// Hardware mode drives control from pins and pins every slot to zero; no slot is refused.
	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			live_cfg[c] = '{ctrl: reg_ctrl_q[c], islot: reg_itr_q[c], oslot: reg_otr_q[c]};
			if (hw_mode)
			begin
				live_cfg[c] = '{ctrl: '0, islot: HW_SLOT, oslot: HW_SLOT};
				{live_cfg[c].ctrl.as2, live_cfg[c].ctrl.as1, live_cfg[c].ctrl.as0} =
					(hw_alg == ALG_24K) ? AS_24K : (hw_alg == ALG_16K) ? AS_16K : AS_32K;
			end
		end
		if (hw_mode)
		begin
			live_cfg[CH_X].ctrl.dir = pf_q.addr[ADDR_DIR_X];
			live_cfg[CH_X].ctrl.law = pf_q.addr[ADDR_LAW_X];
			live_cfg[CH_Y].ctrl.dir = pf_q.addr[ADDR_DIR_Y];
			live_cfg[CH_Y].ctrl.law = pf_q.addr[ADDR_LAW_Y];
			live_cfg[CH_Y].ctrl.idle = pf_q.ser_in;
			live_cfg[CH_X].ctrl.idle = pf_q.port_sel;
		end
	end

	assign status = '{run_y: ch_q[CH_Y].st == CH_RUN, run_x: ch_q[CH_X].st == CH_RUN, alg_y: ch_q[CH_Y].alg,
		alg_x: ch_q[CH_X].alg, low_power: o_low_power, hw_mode: hw_mode};

	// Zero-wait APB slave; read data is latched in the setup cycle so it is stable during access.
	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			reg_ctrl_d[c] = hw_mode ? '0 : reg_ctrl_q[c];
			reg_itr_d[c] = hw_mode ? '0 : reg_itr_q[c];
			reg_otr_d[c] = hw_mode ? '0 : reg_otr_q[c];
		end
		prdata_d = prdata_q;
		apb_hit = 1'b1;
		case (i_paddr)
			REG_X_CTRL: prdata_d = 32'(reg_ctrl_q[CH_X]);
			REG_X_ITR: prdata_d = 32'(reg_itr_q[CH_X]);
			REG_X_OTR: prdata_d = 32'(reg_otr_q[CH_X]);
			REG_Y_CTRL: prdata_d = 32'(reg_ctrl_q[CH_Y]);
			REG_Y_ITR: prdata_d = 32'(reg_itr_q[CH_Y]);
			REG_Y_OTR: prdata_d = 32'(reg_otr_q[CH_Y]);
			REG_STATUS: prdata_d = 32'(status);
			default:
			begin
				prdata_d = 32'h0000_0000;
				apb_hit = 1'b0;
			end
		endcase
		if (!(i_psel && !i_penable))
			prdata_d = prdata_q;
		// Writes land at any time outside hardware mode; each channel picks them up at its next frame start, except the idle bit, which acts at once.
		if (i_psel && i_penable && i_pwrite && !hw_mode)
		begin
			case (i_paddr)
				REG_X_CTRL: reg_ctrl_d[CH_X] = atp_ctrl_t'(i_pwdata[7:0]);
				REG_X_ITR: reg_itr_d[CH_X] = i_pwdata[5:0];
				REG_X_OTR: reg_otr_d[CH_X] = i_pwdata[5:0];
				REG_Y_CTRL: reg_ctrl_d[CH_Y] = atp_ctrl_t'(i_pwdata[7:0]);
				REG_Y_ITR: reg_itr_d[CH_Y] = i_pwdata[5:0];
				REG_Y_OTR: reg_otr_d[CH_Y] = i_pwdata[5:0];
				default: ;
			endcase
		end
	end

	assign o_prdata = prdata_q;
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !apb_hit;

	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			ch_d[c] = ch_q[c];
			// Idle exit waits out the settling time before the port drives again.
			case (ch_q[c].st)
				CH_RUN:
					if (live_cfg[c].ctrl.idle)
						ch_d[c].st = CH_IDLE;
				CH_IDLE:
					if (!live_cfg[c].ctrl.idle)
					begin
						ch_d[c].st = CH_WAKE;
						ch_d[c].wake = '0;
					end
				CH_WAKE:
					if (live_cfg[c].ctrl.idle)
						ch_d[c].st = CH_IDLE;
					else if (ch_q[c].wake >= WAKE_W'(WAKE_CYCLES - 1))
						ch_d[c].st = CH_RUN;
					else
						ch_d[c].wake = ch_q[c].wake + 1'b1;
				default: ch_d[c].st = CH_RUN;
			endcase
			if (rise[c])
			begin
				if (pf_q.fs[c])
				begin
					ch_d[c].armed = 1'b1;
					if (ch_q[c].fs_cnt != FS_SAT)
						ch_d[c].fs_cnt = ch_q[c].fs_cnt + 2'h1;
				end
				else if (ch_q[c].armed)
				begin
					// First rising edge after the sync is bit zero of slot zero.
					ch_d[c].pos = '0;
					ch_d[c].armed = 1'b0;
					ch_d[c].fs_cnt = '0;
					ch_d[c].run = 1'b1;
					ch_d[c].cfg = live_cfg[c];
					ch_d[c].alg = alg_dec(live_cfg[c].ctrl);
					if (ch_d[c].alg == ALG_32K && ch_q[c].fs_cnt >= FS_WIDE)
						ch_d[c].alg = ALG_24K;
					ch_d[c].pad = !hw_mode && live_cfg[c].ctrl.dir && alg_dec(live_cfg[c].ctrl) == ALG_24K;
					// Last frame's result goes out this frame, so latency stays under two frames.
					ch_d[c].word = ch_q[c].res;
				end
				else if (ch_q[c].pos != POS_MAX)
					ch_d[c].pos = ch_q[c].pos + 9'h001;
				ch_d[c].drive = ch_d[c].run && slot_hit(ch_d[c].pos, ch_d[c].cfg.oslot, ch_d[c].cfg.ctrl.dir);
				ch_d[c].so = out_bit(ch_d[c]);
			end
			// Compressing takes 8-bit PCM slots in, expanding takes 4-bit ADPCM slots in.
			if (fall[c] && ch_q[c].run && slot_hit(ch_q[c].pos, ch_q[c].cfg.islot, !ch_q[c].cfg.ctrl.dir))
			begin
				ch_d[c].shift = {ch_q[c].shift[6:0], pf_q.din[c]};
				if (ch_q[c].cfg.ctrl.dir ? (&ch_q[c].pos[2:0]) : (&ch_q[c].pos[1:0]))
					ch_d[c].res = ch_q[c].cfg.ctrl.dir ? {NIB_ZERO, ch_d[c].shift[7:4]} : {ch_d[c].shift[3:0], NIB_ZERO};
			end
			ch_d[c].oe = ch_d[c].drive && ch_q[c].st == CH_RUN && !live_cfg[c].ctrl.idle
				&& !ch_q[c].cfg.ctrl.alrst && !upd;
		end
	end

	assign o_low_power = ch_q[CH_X].st == CH_IDLE && ch_q[CH_Y].st == CH_IDLE;
	assign o_chan_x_serial_out = ch_q[CH_X].so;
	assign o_chan_x_serial_out_oe = ch_q[CH_X].oe;
	assign o_chan_y_serial_out = ch_q[CH_Y].so;
	assign o_chan_y_serial_out_oe = ch_q[CH_Y].oe;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pf_q <= '0;
			clkp_q <= '0;
			rel_cnt_q <= '0;
			a_low_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			for (int c = 0; c < NCH; c++)
			begin
				reg_ctrl_q[c] <= '0;
				reg_itr_q[c] <= '0;
				reg_otr_q[c] <= '0;
				ch_q[c] <= '{st: CH_RUN, alg: ALG_32K, default: '0};
			end
		end
		else
		begin
			s1_q <= pins_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pf_q <= pf_d;
			clkp_q <= pf_q.clk;
			rel_cnt_q <= rel_cnt_d;
			a_low_q <= a_low_d;
			prdata_q <= prdata_d;
			for (int c = 0; c < NCH; c++)
			begin
				reg_ctrl_q[c] <= reg_ctrl_d[c];
				reg_itr_q[c] <= reg_itr_d[c];
				reg_otr_q[c] <= reg_otr_d[c];
				ch_q[c] <= ch_d[c];
			end
		end
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);

	property p_hw_clear;
		hw_mode |=> (reg_ctrl_q[CH_X] == '0 && reg_ctrl_q[CH_Y] == '0 && reg_otr_q[CH_X] == '0);
	endproperty
	a_hw_clear: assert property (p_hw_clear) else $error("register not cleared in hardware mode");

	property p_hw_slot0;
		hw_mode |-> (live_cfg[CH_X].islot == HW_SLOT && live_cfg[CH_Y].oslot == HW_SLOT);
	endproperty
	a_hw_slot0: assert property (p_hw_slot0) else $error("hardware mode slot not zero");

	property p_hw_dir_x;
		hw_mode |-> live_cfg[CH_X].ctrl.dir == pf_q.addr[ADDR_DIR_X];
	endproperty
	a_hw_dir_x: assert property (p_hw_dir_x) else $error("channel X direction not from pin");

	property p_hw_idle_y;
		hw_mode |-> live_cfg[CH_Y].ctrl.idle == pf_q.ser_in;
	endproperty
	a_hw_idle_y: assert property (p_hw_idle_y) else $error("channel Y idle not from pin");

	property p_low_power;
		(live_cfg[CH_X].ctrl.idle && live_cfg[CH_Y].ctrl.idle) [*2] |-> o_low_power;
	endproperty
	a_low_power: assert property (p_low_power) else $error("both idle but no low power");

	property p_wake_bound;
		ch_q[CH_X].st == CH_WAKE |-> ch_q[CH_X].wake < WAKE_CYCLES;
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("wake time exceeded");

	sequence s_wide_start;
		rise[CH_X] && !pf_q.fs[CH_X] && ch_q[CH_X].armed && ch_q[CH_X].fs_cnt >= FS_WIDE
			&& alg_dec(live_cfg[CH_X].ctrl) == ALG_32K;
	endsequence
	property p_cas;
		s_wide_start |=> ch_q[CH_X].alg == ALG_24K;
	endproperty
	a_cas: assert property (p_cas) else $error("double sync did not select 24k");

	property p_upd_tristate;
		upd |=> (!o_chan_x_serial_out_oe && !o_chan_y_serial_out_oe);
	endproperty
	a_upd_tristate: assert property (p_upd_tristate) else $error("output driven during update");

	property p_pad_24;
		(o_chan_x_serial_out_oe && ch_q[CH_X].cfg.ctrl.dir && ch_q[CH_X].alg == ALG_24K
			&& ch_q[CH_X].pos[1:0] == ADPCM_MSB) |-> o_chan_x_serial_out == ch_q[CH_X].pad;
	endproperty
	a_pad_24: assert property (p_pad_24) else $error("24k pad bit wrong");

	property p_oe_slot;
		o_chan_y_serial_out_oe |-> slot_hit(ch_q[CH_Y].pos, ch_q[CH_Y].cfg.oslot, ch_q[CH_Y].cfg.ctrl.dir);
	endproperty
	a_oe_slot: assert property (p_oe_slot) else $error("output driven outside its slot");

endmodule : atp_tdm_port

// ==== tb/atp_tdm_partner.sv ====
// Behavioural codec on the far side of one TDM channel.
`timescale 1ns/100ps
module atp_tdm_partner #(
	parameter int NB = 24,
	parameter int HALF = 4
) (
	input wire logic i_clk_sys,
	input wire logic i_serial_out,
	input wire logic i_serial_out_oe,
	output logic o_bit_clock,
	output logic o_frame_sync,
	output logic o_serial_in
);
	initial
	begin
		o_bit_clock = 1'h0;
		o_frame_sync = 1'h0;
		o_serial_in = 1'h0;
	end

	// The bit clock stands still between frames. Sync moves at falling edges and data at rising
	// edges, so neither changes at the edge on which the port samples it.
	task automatic frame(input logic [31:0] din, input bit wide, output logic [31:0] dq,
		output logic [31:0] oeq);
		int lead;
		lead = wide ? 2 : 1;
		dq = '0;
		oeq = '0;
		o_frame_sync <= 1'h1;
		repeat (HALF) @(posedge i_clk_sys);
		for (int k = 0; k < NB + lead; k++)
		begin
			o_bit_clock <= 1'h1;
			o_serial_in <= (k >= lead) ? din[k - lead] : ~o_serial_in;
			repeat (HALF) @(posedge i_clk_sys);
			o_bit_clock <= 1'h0;
			o_frame_sync <= (k + 1 < lead);
			repeat (HALF) @(posedge i_clk_sys);
			if (k >= lead)
			begin
				dq[k - lead] = i_serial_out;
				oeq[k - lead] = i_serial_out_oe;
			end
		end
		o_serial_in <= ~o_serial_in;
	endtask : frame
endmodule : atp_tdm_partner

// ==== tb/atp_tdm_port_test.sv ====
// Self-checking bench for the dual-channel TDM port.
`timescale 1ns/100ps
module atp_tdm_port_test;
	import atp_pkg::*;
	localparam int WAKE = 20;
	logic clk, srst, psel, penable, pwrite, strap, sin_pin, psel_pin;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, low_power;
	logic [5:0] apin;
	wire [1:0] bclk, fs, sdin, sout, soe;
	logic [7:0] ctrl [2];
	logic [5:0] oslot [2];
	logic [7:0] last_w [2];
	bit idl [2];
	bit sw;
	int fails, check_count;

	atp_tdm_port #(.WAKE_CYCLES(WAKE)) i_atp_tdm_port (
		.i_clk_sys(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_host_mode_strap(strap), .i_addr_pin(apin), .i_serial_in_pin(sin_pin),
		.i_port_select_pin(psel_pin), .i_chan_x_bit_clock(bclk[0]), .i_chan_y_bit_clock(bclk[1]),
		.i_chan_x_frame_sync(fs[0]), .i_chan_y_frame_sync(fs[1]), .i_chan_x_serial_in(sdin[0]),
		.i_chan_y_serial_in(sdin[1]), .o_chan_x_serial_out(sout[0]), .o_chan_x_serial_out_oe(soe[0]),
		.o_chan_y_serial_out(sout[1]), .o_chan_y_serial_out_oe(soe[1]), .o_low_power(low_power));
	atp_tdm_partner i_part_x (.i_clk_sys(clk), .i_serial_out(sout[0]), .i_serial_out_oe(soe[0]),
		.o_bit_clock(bclk[0]), .o_frame_sync(fs[0]), .o_serial_in(sdin[0]));
	atp_tdm_partner i_part_y (.i_clk_sys(clk), .i_serial_out(sout[1]), .i_serial_out_oe(soe[1]),
		.o_bit_clock(bclk[1]), .o_frame_sync(fs[1]), .o_serial_in(sdin[1]));

	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : apb

	task automatic do_reset();
		srst <= 1'h1;
		repeat (6) @(posedge clk);
		srst <= 1'h0;
		repeat (8) @(posedge clk);
	endtask : do_reset

	task automatic setc(input int ch, input logic [7:0] c, input logic [5:0] os);
		logic [31:0] rd;
		logic err;
		ctrl[ch] = c;
		oslot[ch] = os;
		apb(1'h1, ch ? REG_Y_CTRL : REG_X_CTRL, 32'(c), rd, err);
		apb(1'h1, ch ? REG_Y_OTR : REG_X_OTR, 32'(os), rd, err);
		apb(1'h0, ch ? REG_Y_CTRL : REG_X_CTRL, '0, rd, err);
		chk(rd, 32'(c), "control readback");
	endtask : setc

	// The output seen in a frame carries the sample taken in the frame before, in this frame's format.
	task automatic run(input int ch, input logic [7:0] w, input bit wide, input bit on);
		logic [31:0] din, dq, oeq, ed, em;
		logic [7:0] c, v, p;
		int nb;
		bit a24, a16;
		c = ctrl[ch];
		din = '0;
		ed = '0;
		em = '0;
		p = last_w[ch];
		nb = c[0] ? 8 : 4;
		a24 = c[7] & c[6] & c[1];
		a16 = c[7] & !c[6] & c[1];
		for (int i = 0; i < nb; i++)
			din[i] = w[nb - 1 - i];
		if (!c[0])
			v = {p[3:0], 4'h0};
		else if (a24 || (wide && !a16))
			v = {p[7:5], sw && a24, 4'h0};
		else if (a16)
			v = {p[7:6], 6'h00};
		else
			v = {p[7:4], 4'h0};
		for (int i = 0; i < 12 - nb; i++)
		begin
			ed[oslot[ch] * (12 - nb) + i] = v[7 - i];
			em[oslot[ch] * (12 - nb) + i] = 1'h1;
		end
		if (ch == 0)
			i_part_x.frame(din, wide, dq, oeq);
		else
			i_part_y.frame(din, wide, dq, oeq);
		if (idl[ch])
		begin
			ed = '0;
			em = '0;
		end
		if (on)
		begin
			chk(oeq, em, "slot enables");
			chk(dq & oeq, ed, "slot data");
		end
		last_w[ch] = w;
	endtask : run

	initial
	begin
		repeat (40000) @(posedge clk);
		fails++;
		complete_run();
	end

	initial
	begin
		logic [31:0] rd;
		logic err;
		logic [2:0] codes [3];
		srst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		strap = 1'h1;
		apin = 6'h00;
		sin_pin = 1'h0;
		psel_pin = 1'h0;
		sw = 1'h1;
		idl = '{0, 0};
		oslot = '{6'h00, 6'h00};
		codes = '{AS_24K, AS_16K, AS_32K};
		fails = 0;
		check_count = 0;
		void'($urandom(68));
		do_reset();
		apb(1'h0, 8'h0C, '0, rd, err);
		chk({rd[30:0], err}, 32'h0000_0001, "unmapped read");
		setc(0, 8'h05, 6'($urandom % 4));
		setc(1, 8'(($urandom % 2) << 2), 6'($urandom % 2));
		for (int f = 0; f < 4; f++)
		begin
			run(0, 8'($urandom), 0, f > 0);
			run(1, 8'($urandom), 0, f > 0);
		end
		foreach (codes[i])
		begin
			setc(0, {codes[i][0], codes[i][1], 3'h0, 1'($urandom), codes[i][2], 1'h1}, 6'h00);
			run(0, 8'($urandom), 0, 0);
			run(0, 8'($urandom), 0, 1);
		end
		run(0, 8'($urandom), 1, 1);
		run(0, 8'($urandom), 0, 1);
		// The low level for the 24k choice is only judged around reset, so the 24k set-up starts with a reset with both pins low.
		strap <= 1'h0;
		apin <= 6'h17;
		sw = 1'h0;
		oslot = '{6'h00, 6'h00};
		ctrl = '{8'h87, 8'h00};
		do_reset();
		apb(1'h1, REG_X_CTRL, 32'h0000_00FF, rd, err);
		apb(1'h0, REG_X_CTRL, '0, rd, err);
		chk(rd, 32'h0000_0000, "hardware mode register");
		run(0, 8'($urandom), 0, 0);
		run(0, 8'($urandom), 0, 1);
		apin <= 6'h05;
		do_reset();
		repeat (60) @(posedge clk);
		apin <= 6'h17;
		ctrl[0] = 8'hC7;
		run(0, 8'($urandom), 0, 0);
		run(0, 8'($urandom), 0, 1);
		psel_pin <= 1'h1;
		sin_pin <= 1'h1;
		idl = '{1, 1};
		repeat (10) @(posedge clk);
		chk(32'(low_power), 32'h0000_0001, "both idle");
		run(0, 8'($urandom), 0, 1);
		run(1, 8'($urandom), 0, 1);
		psel_pin <= 1'h0;
		idl[0] = 0;
		repeat (WAKE + 10) @(posedge clk);
		chk(32'(low_power), 32'h0000_0000, "one active");
		run(0, 8'($urandom), 0, 0);
		run(0, 8'($urandom), 0, 1);
		complete_run();
	end
endmodule : atp_tdm_port_test
